// *** hw/mfp_pkg.sv ***
// package: register map, field layout and carrier types for the motion fifo port block
package mfp_pkg;
   // printed offsets are hex register numbers, not multiples of four: index * 4 = byte address
   localparam logic [7:0] IDX_LEVEL_HIGH = 8'h72;
   localparam logic [7:0] IDX_LEVEL_LOW = 8'h73;
   localparam logic [7:0] IDX_DATA_PORT = 8'h74;
   localparam logic [7:0] IDX_IDENTITY = 8'h75;
   localparam logic [7:0] IDX_X_TRIM_HIGH = 8'h77;
   localparam logic [7:0] IDX_X_TRIM_LOW = 8'h78;
   localparam logic [7:0] IDX_Y_TRIM_HIGH = 8'h7a;
   localparam logic [7:0] IDX_Y_TRIM_LOW = 8'h7b;
   localparam logic [7:0] IDX_Z_TRIM_HIGH = 8'h7d;
   localparam logic [7:0] IDX_Z_TRIM_LOW = 8'h7e;
   // registers added for control and events
   localparam logic [7:0] IDX_CAPTURE_EN = 8'h23;
   localparam logic [7:0] IDX_AUX_CTRL = 8'h24;
   localparam logic [7:0] IDX_FIFO_MODE = 8'h1a;
   localparam logic [7:0] IDX_IRQ_STATUS = 8'h3a;
   localparam logic [7:0] IDX_IRQ_MASK = 8'h3b;
   // field positions and widths
   localparam int AUX3_EN_BIT = 5;
   localparam int KEEP_OLDEST_BIT = 6;
   localparam int OVERFLOW_BIT = 4;
   localparam int COUNT_W = 13;
   localparam int TRIM_W = 15;
   // reset values
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [TRIM_W-1:0] RST_TRIM = 15'h0000;
   localparam logic [COUNT_W-1:0] RST_COUNT = 13'h0000;
   // sensor source register numbers captured into the fifo
   localparam int SRC_FIRST = 59;
   localparam int SRC_LAST = 96;
   localparam int SRC_N = SRC_LAST - SRC_FIRST + 1;
   // capture groups: index of each register's enable bit in the capture-enable register
   // 59..64 accel(3), 65..66 temp(7), 67..68 gx(6), 69..70 gy(5), 71..72 gz(4),
   // ext 73..96 split over aux slaves 0..3 (bits 0,1,2, aux control bit 5)
   typedef enum logic [1:0] {
      MFP_IDLE = 2'b00,
      MFP_CAPTURE = 2'b01
   } mfp_state_t;
   typedef struct packed {
      logic [7:0] capture_en;
      logic [7:0] aux_ctrl;
      logic [7:0] fifo_mode;
      logic [7:0] irq_status;
      logic [7:0] irq_mask;
      logic [TRIM_W-1:0] x_trim;
      logic [TRIM_W-1:0] y_trim;
      logic [TRIM_W-1:0] z_trim;
   } mfp_cfg_t;
   typedef struct packed {
      logic [7:0] index;
      logic write;
      logic [7:0] wdata;
   } mfp_req_t;
endpackage

// *** hw/mfp_top.sv ***
// motion fifo port: byte fifo, count snapshot, data port, identity and trim registers over apb
//
// The implementer's own choice: the APB slave port.
`timescale 1ns/1ns
module mfp_top #(
   parameter int DEPTH = 512,
   parameter logic [7:0] IDENTITY_CODE = 8'h5a // arbitrary value
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic sample_tick,
   input wire logic [8*mfp_pkg::SRC_N-1:0] sensor_bytes,
   output logic irq,
   output logic [3*mfp_pkg::TRIM_W-1:0] accel_trim
);
   localparam int AW = $clog2(DEPTH);

   // refused at elaboration: pointers wrap by power of two and the count is 13 bits
   if (DEPTH < 2 || DEPTH > 4096 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
      $error("mfp_top: DEPTH must be a power of two from 2 to 4096");
   end

   typedef struct packed {
      mfp_pkg::mfp_state_t state;
      mfp_pkg::mfp_cfg_t cfg;
      logic [AW-1:0] rd_ptr;
      logic [AW-1:0] wr_ptr;
      logic [mfp_pkg::COUNT_W-1:0] count;
      logic [mfp_pkg::COUNT_W-1:0] snap;
      logic [7:0] last_read;
      logic [5:0] src_idx;
      logic [8*mfp_pkg::SRC_N-1:0] frame;
      logic [31:0] prdata;
      logic pready;
      logic pslverr;
      logic irq;
   } mfp_regs_t;

   mfp_regs_t r_q;
   mfp_regs_t r_d;
   logic [7:0] mem_q [DEPTH];
   logic push;
   logic [7:0] push_byte;
   logic [mfp_pkg::SRC_N-1:0] src_en;

   // per-source enable by register number
   genvar g;
   generate
      for (g = 0; g < mfp_pkg::SRC_N; g++) begin : g_en
         localparam int REG = mfp_pkg::SRC_FIRST + g;
         if (REG <= 64) begin : g_acc
            assign src_en[g] = r_q.cfg.capture_en[3];
         end else if (REG <= 66) begin : g_tmp
            assign src_en[g] = r_q.cfg.capture_en[7];
         end else if (REG <= 68) begin : g_gx
            assign src_en[g] = r_q.cfg.capture_en[6];
         end else if (REG <= 70) begin : g_gy
            assign src_en[g] = r_q.cfg.capture_en[5];
         end else if (REG <= 72) begin : g_gz
            assign src_en[g] = r_q.cfg.capture_en[4];
         end else if (REG <= 78) begin : g_s0
            assign src_en[g] = r_q.cfg.capture_en[0];
         end else if (REG <= 84) begin : g_s1
            assign src_en[g] = r_q.cfg.capture_en[1];
         end else if (REG <= 90) begin : g_s2
            assign src_en[g] = r_q.cfg.capture_en[2];
         end else begin : g_s3
            // slave 3 data needs the extra enable
            assign src_en[g] = r_q.cfg.aux_ctrl[mfp_pkg::AUX3_EN_BIT];
         end
      end
   endgenerate

   logic setup;
   logic access;
   logic addr_ok;
   logic [7:0] idx;
   logic full;
   logic empty;
   logic pop;
   logic host_push;
   logic cap_push;
   logic drop_old;
   logic overflow;

   always_comb begin
      r_d = r_q;
      setup = psel && !penable && !r_q.pready;
      access = psel && penable && r_q.pready;
      idx = paddr[9:2];
      addr_ok = (paddr[1:0] == 2'b00) && (paddr[31:10] == 22'h000000);
      full = (r_q.count == mfp_pkg::COUNT_W'(DEPTH));
      empty = (r_q.count == mfp_pkg::RST_COUNT);
      pop = 1'b0;
      host_push = 1'b0;
      cap_push = 1'b0;
      push_byte = pwdata[7:0];
      // zero-wait-state slave: answer registered in setup, taken in access
      r_d.pready = setup;
      r_d.prdata = 32'h00000000;
      r_d.pslverr = 1'b0;
      if (setup) begin
         r_d.pslverr = !addr_ok;
         if (addr_ok && !pwrite) begin
            unique case (idx)
               mfp_pkg::IDX_LEVEL_HIGH: begin
                  r_d.snap = r_q.count;
                  r_d.prdata = {27'h0000000, r_q.count[12:8]};
               end
               mfp_pkg::IDX_LEVEL_LOW: r_d.prdata = {24'h000000, r_q.snap[7:0]};
               mfp_pkg::IDX_DATA_PORT: begin
                  if (empty) begin
                     r_d.prdata = {24'h000000, r_q.last_read};
                  end else begin
                     pop = 1'b1;
                     r_d.prdata = {24'h000000, mem_q[r_q.rd_ptr]};
                     r_d.last_read = mem_q[r_q.rd_ptr];
                  end
               end
               mfp_pkg::IDX_IDENTITY: r_d.prdata = {24'h000000, IDENTITY_CODE};
               mfp_pkg::IDX_X_TRIM_HIGH: r_d.prdata = {24'h000000, r_q.cfg.x_trim[14:7]};
               mfp_pkg::IDX_X_TRIM_LOW: r_d.prdata = {24'h000000, r_q.cfg.x_trim[6:0], 1'b0};
               mfp_pkg::IDX_Y_TRIM_HIGH: r_d.prdata = {24'h000000, r_q.cfg.y_trim[14:7]};
               mfp_pkg::IDX_Y_TRIM_LOW: r_d.prdata = {24'h000000, r_q.cfg.y_trim[6:0], 1'b0};
               mfp_pkg::IDX_Z_TRIM_HIGH: r_d.prdata = {24'h000000, r_q.cfg.z_trim[14:7]};
               mfp_pkg::IDX_Z_TRIM_LOW: r_d.prdata = {24'h000000, r_q.cfg.z_trim[6:0], 1'b0};
               mfp_pkg::IDX_CAPTURE_EN: r_d.prdata = {24'h000000, r_q.cfg.capture_en};
               mfp_pkg::IDX_AUX_CTRL: r_d.prdata = {24'h000000, r_q.cfg.aux_ctrl};
               mfp_pkg::IDX_FIFO_MODE: r_d.prdata = {24'h000000, r_q.cfg.fifo_mode};
               mfp_pkg::IDX_IRQ_STATUS: r_d.prdata = {24'h000000, r_q.cfg.irq_status};
               mfp_pkg::IDX_IRQ_MASK: r_d.prdata = {24'h000000, r_q.cfg.irq_mask};
               default: r_d.pslverr = 1'b1;
            endcase
         end
      end
      // writes take effect at the access edge
      if (access && !r_q.pslverr && pwrite && pstrb[0]) begin
         unique case (idx)
            mfp_pkg::IDX_DATA_PORT: host_push = 1'b1;
            mfp_pkg::IDX_X_TRIM_HIGH: r_d.cfg.x_trim[14:7] = pwdata[7:0];
            mfp_pkg::IDX_X_TRIM_LOW: r_d.cfg.x_trim[6:0] = pwdata[7:1];
            mfp_pkg::IDX_Y_TRIM_HIGH: r_d.cfg.y_trim[14:7] = pwdata[7:0];
            mfp_pkg::IDX_Y_TRIM_LOW: r_d.cfg.y_trim[6:0] = pwdata[7:1];
            mfp_pkg::IDX_Z_TRIM_HIGH: r_d.cfg.z_trim[14:7] = pwdata[7:0];
            mfp_pkg::IDX_Z_TRIM_LOW: r_d.cfg.z_trim[6:0] = pwdata[7:1];
            mfp_pkg::IDX_CAPTURE_EN: r_d.cfg.capture_en = pwdata[7:0];
            mfp_pkg::IDX_AUX_CTRL: r_d.cfg.aux_ctrl = pwdata[7:0];
            mfp_pkg::IDX_FIFO_MODE: r_d.cfg.fifo_mode = pwdata[7:0];
            mfp_pkg::IDX_IRQ_STATUS: r_d.cfg.irq_status = r_q.cfg.irq_status & ~pwdata[7:0];
            mfp_pkg::IDX_IRQ_MASK: r_d.cfg.irq_mask = pwdata[7:0];
            default: r_d.cfg = r_q.cfg;
         endcase
      end
      // capture sequencer: one source per cycle, disabled sources take their cycle but push nothing
      unique case (r_q.state)
         mfp_pkg::MFP_IDLE: begin
            if (sample_tick) begin
               r_d.frame = sensor_bytes;
               r_d.src_idx = 6'h00;
               r_d.state = mfp_pkg::MFP_CAPTURE;
            end
         end
         mfp_pkg::MFP_CAPTURE: begin
            // host write wins the port this cycle; capture waits one cycle
            if (!host_push) begin
               cap_push = src_en[r_q.src_idx];
               r_d.src_idx = r_q.src_idx + 6'h01;
               if (r_q.src_idx == 6'(mfp_pkg::SRC_N - 1)) begin
                  r_d.state = mfp_pkg::MFP_IDLE;
               end
            end
         end
         default: r_d.state = mfp_pkg::MFP_IDLE;
      endcase
      if (cap_push) begin
         push_byte = r_q.frame[8*r_q.src_idx +: 8];
      end
      push = host_push || cap_push;
      overflow = push && full && !pop;
      drop_old = overflow && !r_q.cfg.fifo_mode[mfp_pkg::KEEP_OLDEST_BIT];
      if (overflow) begin
         // set wins over a same-cycle clear
         r_d.cfg.irq_status[mfp_pkg::OVERFLOW_BIT] = 1'b1;
      end
      if (pop || drop_old) begin
         r_d.rd_ptr = r_q.rd_ptr + AW'(1);
      end
      if (push && (!overflow || drop_old)) begin
         r_d.wr_ptr = r_q.wr_ptr + AW'(1);
      end
      // count only moves when a byte is really added or removed
      if (push && !full && !pop) begin
         r_d.count = r_q.count + mfp_pkg::COUNT_W'(1);
      end else if (pop && !push) begin
         r_d.count = r_q.count - mfp_pkg::COUNT_W'(1);
      end
      r_d.irq = |(r_d.cfg.irq_status & r_d.cfg.irq_mask);
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         r_q <= '0;
      end else begin
         r_q <= r_d;
      end
   end

   // storage array has no reset; contents are only read once written
   always_ff @(posedge pclk) begin
      if (push && (!overflow || drop_old)) begin
         mem_q[r_q.wr_ptr] <= push_byte;
      end
   end

   assign prdata = r_q.prdata;
   assign pready = r_q.pready;
   assign pslverr = r_q.pslverr;
   assign irq = r_q.irq;
   // trim drives the accel_trim output unchanged, z_trim on top, x_trim in the low bits
   assign accel_trim = {r_q.cfg.z_trim, r_q.cfg.y_trim, r_q.cfg.x_trim};
endmodule // mfp_top

// *** testbench/mfp_monitor.sv ***
// checker for apb timing, read values and trim outputs of the fifo port
`timescale 1ns/1ns
module mfp_monitor #(parameter logic [7:0] IDENTITY_CODE = 8'h5a) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic irq,
   input wire logic [3*mfp_pkg::TRIM_W-1:0] accel_trim
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire logic rd = pready && !pwrite;
   wire logic [7:0] wbyte = pwdata[7:0];
   AST_READY_NEXT: assert property (psel && !penable |=> pready)
      else $error("no answer after setup");
   AST_READY_PULSE: assert property (pready |=> !pready)
      else $error("ready held too long");
   AST_UPPER_ZERO: assert property (rd |-> prdata[31:8] == 24'h0)
      else $error("upper read bits set");
   AST_ID_CODE: assert property (
      rd && paddr == 32'h1d4 |-> prdata[7:0] == IDENTITY_CODE) else $error("bad identity");
   AST_HIGH_RSVD: assert property (
      rd && paddr == 32'h1c8 |-> prdata[7:5] == 3'h0) else $error("count high reserved set");
   AST_TRIM_BIT0: assert property (
      rd && paddr inside {32'h1e0, 32'h1ec, 32'h1f8} |-> !prdata[0]) else $error("trim bit0 set");
   AST_TRIM_WR: assert property (
      pready && pwrite && paddr == 32'h1dc |=> accel_trim[14:7] == $past(wbyte))
      else $error("trim high not stored");
   AST_TRIM_HOLD: assert property (
      !$stable(accel_trim) |-> $past(psel) && $past(pwrite)) else $error("trim moved alone");
   AST_ERR_RANGE: assert property (pready && paddr >= 32'h400 |-> pslverr)
      else $error("out of range not refused");
   cover property (rd && paddr == 32'h1d0);
   cover property ($rose(irq));
   cover property (pready && pslverr);
endmodule // mfp_monitor
bind mfp_top mfp_monitor #(.IDENTITY_CODE(IDENTITY_CODE)) u_mon (.pclk, .presetn, .psel,
   .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .irq, .accel_trim);

// *** testbench/mfp_host.sv ***
// host model: apb master issuing single register transfers
`timescale 1ns/1ns
module mfp_host (
   input wire logic pclk,
   output logic psel = 1'b0,
   output logic penable = 1'b0,
   output logic pwrite = 1'b0,
   output logic [31:0] paddr = 32'h0,
   output logic [31:0] pwdata = 32'h0,
   output logic [3:0] pstrb = 4'hf,
   input wire logic [31:0] prdata,
   input wire logic pready
);
   // request stays put until pready is seen at an edge, released only after it
   task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
         output logic [31:0] r);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      r = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
endmodule // mfp_host

// *** testbench/mfp_top_tb.sv ***
// testbench: fifo port block over apb against a modelled byte buffer
`timescale 1ns/1ns
module mfp_top_tb;
   localparam int DEPTH = 64;
   localparam logic [7:0] ID = 8'h3c; // arbitrary value
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel, penable, pwrite, pready, pslverr, irq, keep, ovf;
   logic [31:0] paddr, pwdata, prdata, r;
   logic [3:0] pstrb;
   logic sample_tick = 1'b0;
   logic [8*mfp_pkg::SRC_N-1:0] sensor_bytes = '0;
   logic [8*mfp_pkg::SRC_N-1:0] sv;
   logic [3*mfp_pkg::TRIM_W-1:0] accel_trim;
   logic [8:0] expq[$];
   logic [8:0] e;
   logic [7:0] fifo[$];
   logic [7:0] b;
   logic [7:0] last = 8'h0;
   logic [14:0] t;
   logic [15:0] cases[4] = '{16'h8800, 16'h7020, 16'h0700, 16'hff20};
   int mismatches = 0;
   int check_count = 0;
   int cycles = 0;
   always #4 pclk = ~pclk;
   mfp_top #(.DEPTH(DEPTH), .IDENTITY_CODE(ID)) DUT (.pclk, .presetn, .psel, .penable,
      .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .sample_tick,
      .sensor_bytes, .irq, .accel_trim);
   mfp_host host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
      .pready);
   task automatic check(input logic [14:0] seen, input logic [14:0] exp, input string what);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      $display("checks %0d, mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         mismatches++;
         complete_run();
      end
   end
   // each finished read takes the oldest note; bit 8 of a note means a refusal
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) begin
         e = expq.pop_front();
         if (e[8]) check(15'(pslverr), 15'h1, "refusal");
         else check(15'({pslverr, prdata[7:0]}), 15'(e), "read");
      end
   end
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      host.xfer(1'b1, {22'h0, idx, 2'b00}, {24'h0, d}, r);
   endtask
   task automatic rd(input logic [7:0] idx, input logic [8:0] x);
      expq.push_back(x);
      host.xfer(1'b0, {22'h0, idx, 2'b00}, 32'h0, r);
   endtask
   // a read that must be refused: out of range or misaligned
   task automatic rd_bad(input logic [31:0] a);
      expq.push_back(9'h100);
      host.xfer(1'b0, a, 32'h0, r);
   endtask
   task automatic put(input logic [7:0] v);
      if (fifo.size() < DEPTH) fifo.push_back(v);
      else begin
         ovf = 1'b1;
         if (!keep) begin
            void'(fifo.pop_front());
            fifo.push_back(v);
         end
      end
   endtask
   // count is read before any pop, so the port is never read past empty except on purpose
   task automatic drain;
      rd(8'h72, 9'(fifo.size() >> 8));
      rd(8'h73, 9'(fifo.size() & 255));
      while (fifo.size() > 0) begin
         last = fifo.pop_front();
         rd(8'h74, {1'b0, last});
      end
      rd(8'h74, {1'b0, last});
   endtask
   function automatic logic en(int k, logic [7:0] ce, logic [7:0] ax);
      return k < 6 ? ce[3] : k < 8 ? ce[7] : k < 10 ? ce[6] : k < 12 ? ce[5] : k < 14 ? ce[4]
         : k < 20 ? ce[0] : k < 26 ? ce[1] : k < 32 ? ce[2] : ax[5];
   endfunction
   task automatic capture(input logic [7:0] ce, input logic [7:0] ax);
      wr(8'h23, ce);
      wr(8'h24, ax);
      rd(8'h23, {1'b0, ce});
      rd(8'h24, {1'b0, ax});
      for (int k = 0; k < mfp_pkg::SRC_N; k++) sv[8*k+:8] = 8'($urandom);
      @(posedge pclk);
      sensor_bytes <= sv;
      sample_tick <= 1'b1;
      @(posedge pclk);
      sample_tick <= 1'b0;
      for (int k = 0; k < mfp_pkg::SRC_N; k++) if (en(k, ce, ax)) put(sv[8*k+:8]);
      repeat (40) @(posedge pclk);
   endtask
   initial begin
      void'($urandom(32'h42c9));
      repeat (6) @(posedge pclk);
      presetn <= 1'b1;
      wr(8'h75, 8'hff);
      rd(8'h75, {1'b0, ID});
      for (int i = 0; i < 6; i++) rd(8'h77 + 8'(3 * (i / 2) + i % 2), 9'h0);
      rd(8'h74, 9'h0);
      rd(8'h00, 9'h100);
      rd_bad(32'h00000400);
      rd_bad(32'h000001d2);
      for (int a = 0; a < 3; a++) begin
         t = 15'($urandom);
         wr(8'h77 + 8'(3 * a), t[14:7]);
         wr(8'h78 + 8'(3 * a), {t[6:0], 1'b1});
         rd(8'h77 + 8'(3 * a), {1'b0, t[14:7]});
         rd(8'h78 + 8'(3 * a), {1'b0, t[6:0], 1'b0});
         check(accel_trim[15*a+:15], t, "trim");
      end
      rd(8'h72, 9'h0);
      // misaligned data-port write is refused and must not reach the buffer
      host.xfer(1'b1, 32'h000001d1, 32'h000000a5, r);
      for (int i = 0; i < 3; i++) begin
         b = 8'($urandom);
         wr(8'h74, b);
         put(b);
      end
      rd(8'h73, 9'h0);
      drain();
      keep = 1'b0;
      foreach (cases[i]) begin
         capture(cases[i][15:8], cases[i][7:0]);
         drain();
      end
      for (int m = 0; m < 2; m++) begin
         keep = m[0];
         ovf = 1'b0;
         wr(8'h3b, 8'h10);
         wr(8'h1a, {1'b0, keep, 6'h0});
         rd(8'h1a, {2'b00, keep, 6'h0});
         rd(8'h3b, 9'h010);
         capture(8'hff, 8'h20);
         capture(8'hff, 8'h20);
         check(15'(irq), 15'(ovf), "irq raised");
         rd(8'h3a, {4'h0, ovf, 4'h0});
         wr(8'h3b, 8'h00);
         repeat (2) @(posedge pclk);
         check(15'(irq), 15'h0, "irq masked");
         wr(8'h3a, 8'h10);
         rd(8'h3a, 9'h000);
         repeat (2) @(posedge pclk);
         drain();
      end
      complete_run();
   end
endmodule // mfp_top_tb
